// ===== rtl/sscsup_pkg.sv
package sscsup_pkg;

  // internal supervision tick: 10 ms resolves tenths of a second
  localparam int unsigned CLK_HZ          = 125000000;
  localparam int unsigned TICK_MS         = 10;
  localparam int unsigned TICK_CYCLES     = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned TICKS_PER_TENTH = 10;

  // register offsets
  localparam logic [3:0] SSC_CFG_OFS   = 4'h0;
  localparam logic [3:0] SSC_DLY_OFS   = 4'h1;
  localparam logic [3:0] SSC_COM_OFS   = 4'h2;
  localparam logic [3:0] SSC_CMD_OFS   = 4'h3;
  localparam logic [3:0] SSC_STAT_OFS  = 4'h4;
  localparam logic [3:0] SSC_FAULT_OFS = 4'h5;

  // cfg field positions
  localparam int CFG_INLINE_OFF_BIT = 0;
  localparam int CFG_BYP_EN_BIT     = 1;
  localparam int CFG_KSTOP_EN_BIT   = 2;
  localparam int CFG_KPD_SRC_BIT    = 3;
  localparam int CFG_AUTO_LSB       = 4;
  localparam int CFG_FAULT_CLR_BIT  = 6;

  // delay fields in tenths of a second
  localparam logic [6:0] INLINE_DLY_MAX = 7'h64;
  localparam logic [6:0] INLINE_DLY_RST = 7'h1e;
  localparam logic [5:0] BYP_DLY_MIN    = 6'h01;
  localparam logic [5:0] BYP_DLY_MAX    = 6'h32;
  localparam logic [5:0] BYP_DLY_RST    = 6'h14;

  // serial settings
  localparam logic [6:0] COM_TMO_MAX  = 7'h78;
  localparam logic [6:0] COM_TMO_RST  = 7'h00;
  localparam logic [7:0] COM_ADDR_MIN = 8'h01;
  localparam logic [7:0] COM_ADDR_MAX = 8'hf7;
  localparam logic [7:0] COM_ADDR_RST = 8'h01;

  localparam logic [7:0] FAULT_NO_LINE = 8'h01;
  localparam logic [7:0] FAULT_BYPASS  = 8'h30;
  localparam logic [7:0] FAULT_COM_TMO = 8'h52;

  typedef enum logic [2:0]
  {
    BAUD_1200  = 3'h0,
    BAUD_2400  = 3'h1,
    BAUD_4800  = 3'h2,
    BAUD_9600  = 3'h3,
    BAUD_19200 = 3'h4
  } sscsup_baud_type;

  typedef enum logic [1:0]
  {
    FRM_EVEN_1 = 2'h0,
    FRM_ODD_1  = 2'h1,
    FRM_NONE_1 = 2'h2,
    FRM_NONE_2 = 2'h3
  } sscsup_frame_type;

  typedef enum logic [1:0]
  {
    AUTO_OFF   = 2'h0,
    AUTO_POWER = 2'h1,
    AUTO_FAULT = 2'h2,
    AUTO_BOTH  = 2'h3
  } sscsup_auto_type;

  typedef enum logic [3:0]
  {
    MCMD_NONE      = 4'h0,
    MCMD_BIST_STD  = 4'h1,
    MCMD_BIST_PWR  = 4'h2,
    MCMD_CLR_RT    = 4'h3,
    MCMD_CLR_KWH   = 4'h4,
    MCMD_REFLASH   = 4'h5,
    MCMD_STORE     = 4'h6,
    MCMD_LOAD      = 4'h7,
    MCMD_FACTORY   = 4'h8
  } sscsup_mcmd_type;

  typedef struct packed
  {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } sscsup_bus_type;

  typedef struct packed
  {
    logic unpowered_self_test_cmd;
    logic line_powered_self_test_cmd;
    logic clear_runtime_cmd;
    logic clear_energy_meter_cmd;
    logic store_cmd;
    logic load_cmd;
    logic factory_cmd;
  } sscsup_cmd_type;

  localparam sscsup_baud_type  BAUD_RST  = BAUD_19200;
  localparam sscsup_frame_type FRAME_RST = FRM_EVEN_1;

endpackage

// ===== rtl/sscsup_delay.sv
`timescale 1ns/1ps
`default_nettype none

// counts tenths of a second while cond holds; restarts when it drops
module sscsup_delay
  import sscsup_pkg::*;
#(
  parameter int W = 7
)
(
  input  wire logic         clk_i,    // clock
  input  wire logic         rst_i,    // async reset
  input  wire logic         tenth_i,  // 0.1 s enable pulse
  input  wire logic         cond_i,   // qualifying condition
  input  wire logic [W-1:0] limit_i,  // delay in tenths
  output logic              done_o    // held after limit reached
);

  logic [W-1:0] cnt_r;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cnt_r  <= '0;
      done_o <= 1'b0;
    end
    else if (!cond_i)
    begin
      cnt_r  <= '0;
      done_o <= 1'b0;
    end
    else if (cnt_r >= limit_i)
      done_o <= 1'b1;
    else if (tenth_i)
      cnt_r  <= cnt_r + 1'b1;
  end

endmodule

`default_nettype wire

// ===== rtl/sscsup_top.sv
`timescale 1ns/1ps
`default_nettype none

module sscsup_top
  import sscsup_pkg::*;
(
  input  wire logic           clk_i,          // 125 MHz clock
  input  wire logic           rst_i,          // async reset, control power
  input  wire sscsup_bus_type bus_i,          // register port
  output logic [7:0]          rdata_o,        // read data, cycle after rd
  input  wire logic           line_ok_i,      // line voltage sensed
  input  wire logic           start_i,        // start input level
  input  wire logic           kpd_stop_i,     // keypad stop key pulse
  input  wire logic           byp_fbk_i,      // bypass aux contact
  input  wire logic           valid_req_i,    // valid serial request pulse
  input  wire logic           idle_i,         // starter idle
  output logic                run_o,          // run command
  output logic                ctl_stop_o,     // controlled stop pulse
  output logic                ready_o,        // ready condition
  output logic                no_line_alarm_o, // no-line alarm
  output logic                fault_o,        // tripped
  output logic [7:0]          fault_code_o,   // fault number
  output logic                reflash_o,      // reflash mode
  output logic                up_to_speed_relay, // up-to-speed relay
  output sscsup_cmd_type      cmd_o,          // one-cycle command pulses
  output sscsup_baud_type     baud_o,         // serial rate
  output sscsup_frame_type    frame_o,        // serial framing
  output logic [7:0]          node_addr_o     // slave address
);

  logic [7:0]       cfg_r;
  logic [6:0]       inline_dly_r;
  logic [5:0]       byp_dly_r;
  logic [6:0]       com_tmo_r;
  logic             fault_clr;
  logic [20:0]      tick_cnt_r;
  logic             tick_r;
  logic [3:0]       tenth_cnt_r;
  logic             tenth_r;
  logic [3:0]       sec_cnt_r;
  logic             start_d_r;
  logic             pwr_chk_r;
  logic             start_req;
  logic             stop_req;
  logic             nl_done;
  logic             byp_done;
  logic             tmo_done;
  logic [10:0]      tmo_lim;
  logic             inline_off;
  logic             auto_pwr;
  logic             auto_flt;
  logic             nl_wait_r;
  logic             uts_cnt_r;

  assign inline_off = cfg_r[CFG_INLINE_OFF_BIT];
  assign auto_pwr   = cfg_r[CFG_AUTO_LSB];
  assign auto_flt   = cfg_r[CFG_AUTO_LSB+1];
  assign fault_clr  = bus_i.wr && bus_i.addr == SSC_CFG_OFS
                      && bus_i.wdata[CFG_FAULT_CLR_BIT];

  // timebase: 10 ms tick, then 0.1 s enable
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      tick_cnt_r  <= '0;
      tick_r      <= 1'b0;
      tenth_cnt_r <= '0;
      tenth_r     <= 1'b0;
    end
    else
    begin
      tick_r  <= 1'b0;
      tenth_r <= 1'b0;
      if (tick_cnt_r == 21'(TICK_CYCLES - 1))
      begin
        tick_cnt_r <= '0;
        tick_r     <= 1'b1;
      end
      else
        tick_cnt_r <= tick_cnt_r + 1'b1;
      if (tick_r)
      begin
        if (tenth_cnt_r == 4'(TICKS_PER_TENTH - 1))
        begin
          tenth_cnt_r <= '0;
          tenth_r     <= 1'b1;
        end
        else
          tenth_cnt_r <= tenth_cnt_r + 1'b1;
      end
    end
  end

  // registers written by software
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cfg_r        <= 8'h04;
      inline_dly_r <= INLINE_DLY_RST;
      byp_dly_r    <= BYP_DLY_RST;
      com_tmo_r    <= COM_TMO_RST;
      baud_o       <= BAUD_RST;
      frame_o      <= FRAME_RST;
    end
    else if (bus_i.wr && !reflash_o)
    begin
      case (bus_i.addr)
        SSC_CFG_OFS:
          cfg_r <= {1'b0, bus_i.wdata[6:0]} & 8'h3f;
        SSC_DLY_OFS:
        begin
          if (bus_i.wdata[7])
          begin
            if (bus_i.wdata[5:0] >= BYP_DLY_MIN && bus_i.wdata[5:0] <= BYP_DLY_MAX)
              byp_dly_r <= bus_i.wdata[5:0];
          end
          else if (bus_i.wdata[6:0] <= INLINE_DLY_MAX)
            inline_dly_r <= bus_i.wdata[6:0];
        end
        SSC_COM_OFS:
        begin
          // timeout needs 7 bits to reach 120 s, so it owns all of b7=0
          if (!bus_i.wdata[7])
          begin
            if (bus_i.wdata[6:0] <= COM_TMO_MAX)
              com_tmo_r <= bus_i.wdata[6:0];
          end
          else if (!bus_i.wdata[6])
          begin
            if (bus_i.wdata[2:0] <= 3'(BAUD_19200))
              baud_o <= sscsup_baud_type'(bus_i.wdata[2:0]);
          end
          else
            frame_o <= sscsup_frame_type'(bus_i.wdata[1:0]);
        end
        default:
          ;
      endcase
    end
  end

  // node address written as a whole byte at offset 6
  // kept apart: the range check needs all 8 bits
  logic addr_wr;
  assign addr_wr = bus_i.wr && bus_i.addr == 4'h6 && !reflash_o;

  // misc command dispatcher
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cmd_o     <= '0;
      reflash_o <= 1'b0;
    end
    else
    begin
      cmd_o <= '0;
      // codes above 8 carry no command, upper nibble included
      if (bus_i.wr && bus_i.addr == SSC_CMD_OFS && !reflash_o
          && bus_i.wdata[7:4] == 4'h0)
      begin
        case (bus_i.wdata[3:0])
          MCMD_BIST_STD:
            cmd_o.unpowered_self_test_cmd <= 1'b1;
          MCMD_BIST_PWR:
            cmd_o.line_powered_self_test_cmd <= 1'b1;
          MCMD_CLR_RT:
            cmd_o.clear_runtime_cmd <= 1'b1;
          MCMD_CLR_KWH:
            cmd_o.clear_energy_meter_cmd <= 1'b1;
          MCMD_REFLASH:
            reflash_o <= idle_i && !run_o;
          MCMD_STORE:
            cmd_o.store_cmd <= 1'b1;
          MCMD_LOAD:
            cmd_o.load_cmd <= 1'b1;
          MCMD_FACTORY:
            cmd_o.factory_cmd <= 1'b1;
          default:
            ;
        endcase
      end
    end
  end

  // start qualification
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      start_d_r <= 1'b1;
      pwr_chk_r <= 1'b1;
    end
    else
    begin
      start_d_r <= start_i;
      pwr_chk_r <= 1'b0;
    end
  end

  // fault reset start must bypass the fault gate: fault is still set then
  assign start_req = !reflash_o &&
                     ((!fault_o && start_i && !start_d_r) ||
                      (!fault_o && pwr_chk_r && auto_pwr && start_i) ||
                      (fault_o && fault_clr && auto_flt && start_i));
  assign stop_req  = kpd_stop_i && (cfg_r[CFG_KSTOP_EN_BIT]
                     || cfg_r[CFG_KPD_SRC_BIT]);

  // delay timers
  assign tmo_lim = 11'(com_tmo_r) * 11'd10;

  sscsup_delay #(.W(7)) u_nl
  (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .tenth_i (tenth_r),
    .cond_i  (nl_wait_r && !line_ok_i),
    .limit_i (inline_dly_r),
    .done_o  (nl_done)
  );

  sscsup_delay #(.W(6)) u_byp
  (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .tenth_i (tenth_r),
    .cond_i  (cfg_r[CFG_BYP_EN_BIT] && byp_fbk_i != up_to_speed_relay),
    .limit_i (byp_dly_r),
    .done_o  (byp_done)
  );

  sscsup_delay #(.W(11)) u_tmo
  (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .tenth_i (tenth_r),
    .cond_i  (com_tmo_r != '0 && run_o && !valid_req_i),
    .limit_i (tmo_lim),
    .done_o  (tmo_done)
  );

  // run, fault and relay state
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      run_o             <= 1'b0;
      ctl_stop_o        <= 1'b0;
      fault_o           <= 1'b0;
      fault_code_o      <= '0;
      nl_wait_r         <= 1'b0;
      up_to_speed_relay <= 1'b0;
      uts_cnt_r         <= 1'b0;
    end
    else
    begin
      ctl_stop_o <= 1'b0;
      if (fault_clr && !run_o)
      begin
        fault_o      <= 1'b0;
        fault_code_o <= '0;
      end
      if (start_req && !run_o)
      begin
        if (inline_off && !line_ok_i)
        begin
          fault_o      <= 1'b1;
          fault_code_o <= FAULT_NO_LINE;
        end
        else
        begin
          run_o     <= 1'b1;
          nl_wait_r <= !inline_off;
        end
      end
      else if (run_o)
      begin
        if (line_ok_i)
          nl_wait_r <= 1'b0;
        if (nl_done)
        begin
          run_o        <= 1'b0;
          fault_o      <= 1'b1;
          fault_code_o <= FAULT_NO_LINE;
          nl_wait_r    <= 1'b0;
        end
        else if (tmo_done)
        begin
          run_o        <= 1'b0;
          ctl_stop_o   <= 1'b1;
          fault_o      <= 1'b1;
          fault_code_o <= FAULT_COM_TMO;
        end
        else if (stop_req || reflash_o)
          run_o <= 1'b0;
      end
      if (byp_done)
      begin
        run_o        <= 1'b0;
        fault_o      <= 1'b1;
        fault_code_o <= FAULT_BYPASS;
      end
      // up-to-speed relay follows run once line is present
      uts_cnt_r         <= run_o && line_ok_i && !nl_wait_r;
      up_to_speed_relay <= uts_cnt_r && run_o;
    end
  end

  // status: alarm only matters while stopped; ready ignores run
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ready_o         <= 1'b0;
      no_line_alarm_o <= 1'b0;
    end
    else
    begin
      no_line_alarm_o <= inline_off && !run_o && !line_ok_i;
      ready_o         <= !fault_o && !reflash_o &&
                         (!inline_off || line_ok_i);
    end
  end

  // node address and read port
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      rdata_o <= '0;
    else if (bus_i.rd)
    begin
      case (bus_i.addr)
        SSC_CFG_OFS:   rdata_o <= cfg_r;
        SSC_DLY_OFS:   rdata_o <= {1'b0, inline_dly_r};
        SSC_COM_OFS:   rdata_o <= {1'b0, com_tmo_r};
        SSC_STAT_OFS:  rdata_o <= {2'h0, reflash_o, up_to_speed_relay,
                                   no_line_alarm_o, ready_o, fault_o, run_o};
        SSC_FAULT_OFS: rdata_o <= fault_code_o;
        4'h6:          rdata_o <= node_addr_o;
        4'h7:          rdata_o <= {2'h0, byp_dly_r};
        default:       rdata_o <= '0;
      endcase
    end
    else
      rdata_o <= '0;
  end

  // address kept separately so range check sees the raw byte
  logic [7:0] addr_hold_r;
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      addr_hold_r <= COM_ADDR_RST;
    else if (addr_wr && bus_i.wdata >= COM_ADDR_MIN && bus_i.wdata <= COM_ADDR_MAX)
      addr_hold_r <= bus_i.wdata;
  end
  assign node_addr_o = addr_hold_r;

endmodule

`default_nettype wire

// ===== sim/sscsup_props.sv
`timescale 1ns/1ps
`default_nettype none

module sscsup_props
  import sscsup_pkg::*;
(
  input wire logic           clk_i,           // clock
  input wire logic           rst_i,           // reset
  input wire sscsup_bus_type bus_i,           // register port
  input wire logic           line_ok_i,       // line sensed
  input wire logic           start_i,         // start input
  input wire logic           idle_i,          // idle
  input wire logic           run_o,           // run
  input wire logic           ready_o,         // ready
  input wire logic           no_line_alarm_o, // alarm
  input wire logic           fault_o,         // tripped
  input wire logic [7:0]     fault_code_o,    // fault number
  input wire logic           reflash_o,       // reflash
  input wire sscsup_cmd_type cmd_o,           // pulses
  input wire logic [7:0]     node_addr_o      // address
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic       inl_off_r;
  logic       wcmd;
  logic [7:0] wd;
  assign wd = bus_i.wdata;
  assign wcmd = bus_i.wr && bus_i.addr == SSC_CMD_OFS && !reflash_o;

  // mirror of the inline setting, the only config these checks need
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
      inl_off_r <= 1'b0;
    else if (bus_i.wr && bus_i.addr == SSC_CFG_OFS && !reflash_o)
      inl_off_r <= wd[CFG_INLINE_OFF_BIT];

  property p_idle_cmd;
    wcmd && (wd == 8'h00 || wd > 8'h08) |=> cmd_o == 7'h00;
  endproperty
  a_idle_cmd: assert property (p_idle_cmd)
    else $error("pulse on idle code");
  property p_bist;
    wcmd && wd == 8'h01 |=> cmd_o == 7'h40;
  endproperty
  a_bist: assert property (p_bist)
    else $error("self test pulse wrong");
  property p_param;
    wcmd && wd == 8'h08 |=> cmd_o == 7'h01;
  endproperty
  a_param: assert property (p_param)
    else $error("factory pulse wrong");
  property p_nl_alarm;
    (inl_off_r && !line_ok_i && !run_o && !fault_o)[*3] |-> no_line_alarm_o && !ready_o;
  endproperty
  a_nl_alarm: assert property (p_nl_alarm)
    else $error("no alarm without line");
  property p_nl_quiet;
    (!inl_off_r && !run_o)[*2] |-> !no_line_alarm_o;
  endproperty
  a_nl_quiet: assert property (p_nl_quiet)
    else $error("alarm with inline delay");
  property p_nl_fault;
    inl_off_r && !line_ok_i && !run_o && !fault_o && !reflash_o && start_i && !$past(start_i)
      |-> ##[1:8] fault_o && fault_code_o == FAULT_NO_LINE;
  endproperty
  a_nl_fault: assert property (p_nl_fault)
    else $error("no line fault missing");
  property p_refl_in;
    $rose(reflash_o) |-> $past(wcmd && wd == 8'h05 && idle_i);
  endproperty
  a_refl_in: assert property (p_refl_in)
    else $error("reflash entered wrongly");
  property p_addr;
    bus_i.wr && bus_i.addr == 4'h6 && !reflash_o |=> node_addr_o ==
      (($past(wd) >= COM_ADDR_MIN && $past(wd) <= COM_ADDR_MAX) ? $past(wd) : $past(node_addr_o));
  endproperty
  a_addr: assert property (p_addr)
    else $error("node address update wrong");
endmodule

`default_nettype wire

// ===== sim/sscsup_partner.sv
`timescale 1ns/1ps
`default_nettype none

module sscsup_partner
(
  input  wire logic clk_i,   // clock
  input  wire logic rst_i,   // reset
  input  wire logic relay_i, // up-to-speed relay coil
  output logic      fbk_o,   // bypass aux contact
  output logic      req_o    // valid request pulse
);
  logic [3:0] lag_r;
  logic [7:0] gap_r;

  // contact trails the coil by a few cycles, as a real contactor does
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
      lag_r <= 4'h0;
    else
      lag_r <= {lag_r[2:0], relay_i};
  assign fbk_o = lag_r[3];

  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
      gap_r <= 8'h00;
    else
      gap_r <= gap_r + 8'h01;
  assign req_o = (gap_r == 8'hff);
endmodule

`default_nettype wire

// ===== sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench
  import sscsup_pkg::*;
;
  logic             clk_i = 1'b0;
  logic             rst_i = 1'b1;
  sscsup_bus_type   bus = '0;
  logic             line_ok_i, start_i, kpd_stop_i, idle_i, busy, byp_fbk_i, valid_req_i;
  logic [7:0]       rdata_o, fault_code_o, node_addr_o;
  logic             run_o, ctl_stop_o, ready_o, no_line_alarm_o, fault_o, reflash_o;
  logic             up_to_speed_relay;
  sscsup_cmd_type   cmd_o;
  sscsup_baud_type  baud_o;
  sscsup_frame_type frame_o;
  int               fails = 0, cmp_count = 0, cyc = 0;

  assign idle_i = !run_o && !busy;
  always #4 clk_i = ~clk_i;

  sscsup_top i_sscsup_top (.clk_i(clk_i), .rst_i(rst_i), .bus_i(bus), .rdata_o(rdata_o),
    .line_ok_i(line_ok_i), .start_i(start_i), .kpd_stop_i(kpd_stop_i), .byp_fbk_i(byp_fbk_i),
    .valid_req_i(valid_req_i), .idle_i(idle_i), .run_o(run_o), .ctl_stop_o(ctl_stop_o),
    .ready_o(ready_o), .no_line_alarm_o(no_line_alarm_o), .fault_o(fault_o),
    .fault_code_o(fault_code_o), .reflash_o(reflash_o), .up_to_speed_relay(up_to_speed_relay),
    .cmd_o(cmd_o), .baud_o(baud_o), .frame_o(frame_o), .node_addr_o(node_addr_o));
  sscsup_partner i_sscsup_partner (.clk_i(clk_i), .rst_i(rst_i), .relay_i(up_to_speed_relay),
    .fbk_o(byp_fbk_i), .req_o(valid_req_i));

  task chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_i);
    bus.wr <= 1'b0;
    #1;
  endtask
  task rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_i);
    bus.rd <= 1'b0;
    #1;
    chk(rdata_o, exp);
  endtask
  // bounded wait on run (f=0) or fault (f=1)
  task wait_sig(input bit f, input logic v);
    int n;
    n = 0;
    while (((f ? fault_o : run_o) !== v) && n < 40)
    begin
      @(posedge clk_i);
      n++;
    end
    #1;
    chk({7'h0, f ? fault_o : run_o}, {7'h0, v});
  endtask
  task press;
    @(posedge clk_i);
    kpd_stop_i <= 1'b1;
    @(posedge clk_i);
    kpd_stop_i <= 1'b0;
  endtask
  task set_in(input logic line, input logic st);
    @(posedge clk_i);
    line_ok_i <= line;
    start_i <= st;
  endtask

  task t_regs;
    logic [6:0] e [10];
    e = '{7'h00, 7'h40, 7'h20, 7'h10, 7'h08, 7'h00, 7'h04, 7'h02, 7'h01, 7'h00};
    chk({5'h0, baud_o}, 8'h04);
    chk({6'h0, frame_o}, 8'h00);
    chk(node_addr_o, 8'h01);
    rd(SSC_DLY_OFS, 8'h1e);
    rd(4'h7, 8'h14);
    rd(SSC_COM_OFS, 8'h00);
    rd(4'hf, 8'h00);
    for (int c = 0; c < 10; c++)
      if (c != 5)
      begin
        wr(SSC_CMD_OFS, 8'(c));
        chk({1'b0, cmd_o}, {1'b0, e[c]});
      end
    for (int b = 0; b < 6; b++)
    begin
      wr(SSC_COM_OFS, 8'h80 | 8'(b));
      chk({5'h0, baud_o}, b < 5 ? 8'(b) : 8'h04);
    end
    for (int f = 3; f >= 0; f--)
    begin
      wr(SSC_COM_OFS, 8'hc0 | 8'(f));
      chk({6'h0, frame_o}, 8'(f));
    end
    wr(4'h6, 8'h00);
    chk(node_addr_o, 8'h01);
    wr(4'h6, 8'hf7);
    wr(4'h6, 8'hf8);
    chk(node_addr_o, 8'hf7);
    wr(4'h6, 8'h01);
    wr(SSC_COM_OFS, 8'h78);
    wr(SSC_COM_OFS, 8'h79);
    rd(SSC_COM_OFS, 8'h78);
    wr(SSC_DLY_OFS, 8'h64);
    wr(SSC_DLY_OFS, 8'h65);
    rd(SSC_DLY_OFS, 8'h64);
    wr(SSC_DLY_OFS, 8'h80);
    wr(SSC_DLY_OFS, 8'hb2);
    wr(SSC_DLY_OFS, 8'hb3);
    rd(4'h7, 8'h32);
    $display("registers and commands done");
  endtask

  task t_line;
    wr(SSC_CFG_OFS, 8'h05);
    set_in(1'b0, 1'b0);
    repeat (4) @(posedge clk_i);
    #1;
    chk({6'h0, no_line_alarm_o, ready_o}, 8'h02);
    set_in(1'b0, 1'b1);
    wait_sig(1'b1, 1'b1);
    chk(fault_code_o, FAULT_NO_LINE);
    wr(SSC_CFG_OFS, 8'h46);
    repeat (4) @(posedge clk_i);
    #1;
    chk({5'h0, no_line_alarm_o, ready_o, fault_o}, 8'h02);
    chk({7'h0, run_o}, 8'h00);
    set_in(1'b1, 1'b0);
    $display("line supervision done");
  endtask

  task t_kstop;
    wr(SSC_CFG_OFS, 8'h02);
    set_in(1'b1, 1'b1);
    wait_sig(1'b0, 1'b1);
    press;
    repeat (8) @(posedge clk_i);
    #1;
    chk({6'h0, run_o, fault_o}, 8'h02);
    wr(SSC_CFG_OFS, 8'h0a);
    press;
    wait_sig(1'b0, 1'b0);
    wr(SSC_CFG_OFS, 8'h06);
    set_in(1'b1, 1'b0);
    set_in(1'b1, 1'b1);
    wait_sig(1'b0, 1'b1);
    press;
    wait_sig(1'b0, 1'b0);
    $display("keypad stop done");
  endtask

  task t_auto;
    for (int a = 2; a < 4; a++)
    begin
      set_in(1'b0, 1'b0);
      wr(SSC_CFG_OFS, 8'h07 | 8'(a << 4));
      set_in(1'b0, 1'b1);
      wait_sig(1'b1, 1'b1);
      set_in(1'b1, 1'b1);
      wr(SSC_CFG_OFS, 8'h46 | 8'(a << 4));
      wait_sig(1'b0, 1'b1);
      press;
      wait_sig(1'b0, 1'b0);
    end
    $display("auto start done");
  endtask

  task t_reflash;
    @(posedge clk_i);
    busy <= 1'b1;
    wr(SSC_CMD_OFS, 8'h05);
    chk({7'h0, reflash_o}, 8'h00);
    @(posedge clk_i);
    busy <= 1'b0;
    wr(SSC_CMD_OFS, 8'h05);
    chk({7'h0, reflash_o}, 8'h01);
    wr(4'h6, 8'h22);
    set_in(1'b1, 1'b0);
    set_in(1'b1, 1'b1);
    repeat (8) @(posedge clk_i);
    #1;
    chk(node_addr_o, 8'h01);
    chk({6'h0, run_o, reflash_o}, 8'h01);
    $display("reflash done");
  endtask

  task give_verdict;
    $display("compares %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ceiling well above the few hundred cycles the tests need
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      give_verdict;
    end
  end

  initial
  begin
    line_ok_i = 1'b1;
    start_i = 1'b0;
    kpd_stop_i = 1'b0;
    busy = 1'b0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs;
    t_line;
    t_kstop;
    t_auto;
    t_reflash;
    give_verdict;
  end
endmodule

bind sscsup_top sscsup_props i_sscsup_props (.clk_i(clk_i), .rst_i(rst_i), .bus_i(bus_i),
  .line_ok_i(line_ok_i), .start_i(start_i), .idle_i(idle_i), .run_o(run_o), .ready_o(ready_o),
  .no_line_alarm_o(no_line_alarm_o), .fault_o(fault_o), .fault_code_o(fault_code_o),
  .reflash_o(reflash_o), .cmd_o(cmd_o), .node_addr_o(node_addr_o));

`default_nettype wire
